// ==== rtl/btg_defines.vh ====
// Purpose: Constants for the buzzer tone generator
// Assumes: AXI4-Lite register access, 25 MHz system clock
// Notes:   Register byte address is four times the index
//
// Function
// - Enable high drives tone onto pin; enable low holds pin low unless a one-shot runs
// - Three-bit frequency code picks one of eight oscillator-divided tones
// - Duty level sets high fraction, x/16 and x/20 tone groups
// - Duty level sets high fraction, x/24 and x/28 tone groups
// - Envelope enabled overrides duty level field during continuous output
// - Envelope enable bit is read/write and turns envelope on or off
// - Envelope starts at maximum duty, steps down to minimum, holds
// - Step select picks 125 ms or 62.5 ms per envelope step
// - Restart write returns envelope to maximum; ignored when idle or zero
// - Restart, stop and unused bits always read zero
// - Length select picks 125 ms or 31.25 ms one-shot duration
// - Trigger write starts one-shot; ends itself after duration
// - Trigger ignored while continuous output enabled
// - Retrigger during one-shot restarts the duration timer
// - Trigger bit reads one while one-shot output in progress
// - Stop write ends active one-shot early; otherwise ignored
// - One-shot start and stop align to internal 256 Hz tick
// - Tone runs free of enable writes, so on/off may glitch
// - Reset clears all control bits, fields and one-shot status
// - Tones derive from the 32.768 kHz low-speed oscillator clock
`ifndef BTG_DEFINES_VH
`define BTG_DEFINES_VH

// Register indices
`define BTG_IDX_ENV_CTRL   16'hFF6C
`define BTG_IDX_ONESHOT    16'hFF6D
`define BTG_IDX_FREQ       16'hFF6E
`define BTG_IDX_DUTY       16'hFF6F

// Field positions
`define BTG_BIT_ENABLE     0
`define BTG_BIT_ENV_EN     1
`define BTG_BIT_ENV_RST    2
`define BTG_BIT_STEP_SEL   3
`define BTG_BIT_LEN_SEL    0
`define BTG_BIT_TRIGGER    1
`define BTG_BIT_STOP       2

// Reset values
`define BTG_RST_FIELD      3'h0

// Timing in 256 Hz ticks (3.90625 ms each)
`define BTG_STEP_SHORT     6'h10
`define BTG_STEP_LONG      6'h20
`define BTG_SHOT_SHORT     6'h08
`define BTG_SHOT_LONG      6'h20

// Envelope minimum duty level
`define BTG_LEVEL_MIN      3'h7

// AXI responses
`define BTG_RESP_OKAY      2'h0
`define BTG_RESP_SLVERR    2'h2

`endif

// ==== rtl/btg_top.v ====
// Purpose: Buzzer tone generator with envelope and one-shot
// Assumes: Oscillator clock input is asynchronous and slow
// Notes:   Tone timebase counts both oscillator edges
`timescale 1ns/100ps
`default_nettype none
`include "btg_defines.vh"

module btg_top #(
    parameter ADDR_W = 18
) (
    input  wire              clk,
    input  wire              rst,
    input  wire              low_speed_osc_clock,
    output reg               tone_out_pin,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire [2:0]        s_axi_awprot,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire [2:0]        s_axi_arprot,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready
);

    // Oscillator synchroniser and edge detect
    reg        osc_s1_reg;
    reg        osc_s2_reg;
    reg        osc_s3_reg;
    wire       half_tick;
    reg  [7:0] pre_reg;
    reg        tick_reg;

    // Control registers
    reg        enable_reg;
    reg        env_en_reg;
    reg        step_sel_reg;
    reg        len_sel_reg;
    reg  [2:0] freq_reg;
    reg  [2:0] duty_reg;

    // Envelope state
    reg  [2:0] env_level_reg;
    reg  [5:0] env_cnt_reg;
    reg        en_prev_reg;

    // One-shot state
    reg        busy_reg;
    reg        run_reg;
    reg        start_pend_reg;
    reg        stop_pend_reg;
    reg  [5:0] shot_cnt_reg;

    // Tone generator
    reg  [5:0] phase_reg;
    wire [1:0] grp;
    wire [5:0] period;
    wire [5:0] high_time;
    wire [2:0] level;
    wire [3:0] base_high;
    wire       env_active;

    // Bus state
    reg  [ADDR_W-1:0] awaddr_reg;
    reg  [31:0]       wdata_reg;
    reg               wstrb0_reg;
    reg               aw_have_reg;
    reg               w_have_reg;
    wire              wr_fire;
    wire [ADDR_W-3:0] wr_idx;
    wire [ADDR_W-3:0] rd_idx;
    wire              wr_en;
    wire              hit_env;
    wire              hit_shot;
    wire              hit_freq;
    wire              hit_duty;
    wire              restart_req;
    wire              trig_req;
    wire              stop_req;
    wire              en_rise;
    wire [5:0]        step_len;
    wire [5:0]        shot_len;
    reg  [31:0]       rd_data;
    reg               rd_ok;

    always @(posedge clk)
    begin
        if (rst)
        begin
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_s3_reg <= 1'b0;
        end
        else
        begin
            osc_s1_reg <= low_speed_osc_clock;
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
        end
    end

    assign half_tick = osc_s2_reg ^ osc_s3_reg;

    always @(posedge clk)
    begin
        if (rst)
        begin
            pre_reg  <= 8'h00;
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= half_tick && (pre_reg == 8'hFF);
            if (half_tick)
                pre_reg <= pre_reg + 8'h01;
        end
    end

    // Write decode
    assign wr_fire  = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign wr_idx   = awaddr_reg[ADDR_W-1:2];
    assign rd_idx   = s_axi_araddr[ADDR_W-1:2];
    assign wr_en    = wr_fire && wstrb0_reg;
    assign hit_env  = wr_idx == `BTG_IDX_ENV_CTRL;
    assign hit_shot = wr_idx == `BTG_IDX_ONESHOT;
    assign hit_freq = wr_idx == `BTG_IDX_FREQ;
    assign hit_duty = wr_idx == `BTG_IDX_DUTY;

    // restart only while envelope on or tone out
    assign restart_req = wr_en && hit_env
                         && wdata_reg[`BTG_BIT_ENV_RST]
                         && (env_en_reg || enable_reg || run_reg);
    // trigger accepted only with enable low
    assign trig_req = wr_en && hit_shot
                      && wdata_reg[`BTG_BIT_TRIGGER] && !enable_reg;
    assign stop_req = wr_en && hit_shot
                      && wdata_reg[`BTG_BIT_STOP] && busy_reg;

    assign en_rise  = enable_reg && !en_prev_reg;
    assign step_len = step_sel_reg ? `BTG_STEP_LONG : `BTG_STEP_SHORT;
    assign shot_len = len_sel_reg ? `BTG_SHOT_LONG : `BTG_SHOT_SHORT;

    // Control registers
    always @(posedge clk)
    begin
        if (rst)
        begin
            enable_reg   <= 1'b0;
            env_en_reg   <= 1'b0;
            step_sel_reg <= 1'b0;
            len_sel_reg  <= 1'b0;
            freq_reg     <= `BTG_RST_FIELD;
            duty_reg     <= `BTG_RST_FIELD;
        end
        else if (wr_en)
        begin
            if (hit_env)
            begin
                enable_reg   <= wdata_reg[`BTG_BIT_ENABLE];
                env_en_reg   <= wdata_reg[`BTG_BIT_ENV_EN];
                step_sel_reg <= wdata_reg[`BTG_BIT_STEP_SEL];
            end
            else if (hit_shot)
            begin
                len_sel_reg <= wdata_reg[`BTG_BIT_LEN_SEL];
            end
            else if (hit_freq)
            begin
                freq_reg <= wdata_reg[2:0];
            end
            else if (hit_duty)
            begin
                duty_reg <= wdata_reg[2:0];
            end
        end
    end

    // Envelope sequencer
    always @(posedge clk)
    begin
        if (rst)
        begin
            env_level_reg <= 3'h0;
            env_cnt_reg   <= 6'h00;
            en_prev_reg   <= 1'b0;
        end
        else
        begin
            en_prev_reg <= enable_reg;
            // start at maximum on output start
            if (en_rise || restart_req)
            begin
                env_level_reg <= 3'h0;
                env_cnt_reg   <= 6'h00;
            end
            else if (tick_reg && env_active
                     && env_level_reg != `BTG_LEVEL_MIN)
            begin
                if (env_cnt_reg == step_len - 6'h01)
                begin
                    env_cnt_reg   <= 6'h00;
                    env_level_reg <= env_level_reg + 3'h1;
                end
                else
                begin
                    env_cnt_reg <= env_cnt_reg + 6'h01;
                end
            end
        end
    end

    // One-shot controller
    always @(posedge clk)
    begin
        if (rst)
        begin
            busy_reg       <= 1'b0;
            run_reg        <= 1'b0;
            start_pend_reg <= 1'b0;
            stop_pend_reg  <= 1'b0;
            shot_cnt_reg   <= 6'h00;
        end
        else
        begin
            if (trig_req)
            begin
                busy_reg       <= 1'b1;
                start_pend_reg <= 1'b1;
                stop_pend_reg  <= 1'b0;
            end
            else if (stop_req)
            begin
                stop_pend_reg <= 1'b1;
            end
            // start and stop on tick edges
            if (tick_reg && !trig_req)
            begin
                if (start_pend_reg)
                begin
                    run_reg        <= 1'b1;
                    start_pend_reg <= 1'b0;
                    shot_cnt_reg   <= shot_len;
                end
                else if (stop_pend_reg || stop_req)
                begin
                    run_reg       <= 1'b0;
                    busy_reg      <= 1'b0;
                    stop_pend_reg <= 1'b0;
                end
                else if (run_reg)
                begin
                    if (shot_cnt_reg == 6'h01)
                    begin
                        run_reg  <= 1'b0;
                        busy_reg <= 1'b0;
                    end
                    shot_cnt_reg <= shot_cnt_reg - 6'h01;
                end
            end
        end
    end

    assign env_active = env_en_reg && enable_reg;
    assign level      = env_active ? env_level_reg : duty_reg;

    assign grp    = freq_reg[1:0];
    assign period = ({4'h0, grp} + 6'h04) << (freq_reg[2] ? 3 : 2);

    assign base_high = (grp[1] ? 4'hC : 4'h8) - {1'b0, level};
    assign high_time = {2'h0, base_high} << (freq_reg[2] ? 1 : 0);

    // phase counter runs regardless of enable
    always @(posedge clk)
    begin
        if (rst)
        begin
            phase_reg    <= 6'h00;
            tone_out_pin <= 1'b0;
        end
        else
        begin
            if (half_tick)
            begin
                if (phase_reg >= period - 6'h01)
                    phase_reg <= 6'h00;
                else
                    phase_reg <= phase_reg + 6'h01;
            end
            tone_out_pin <= (enable_reg || run_reg)
                            && (phase_reg < high_time);
        end
    end

    // AXI write channel
    always @(posedge clk)
    begin
        if (rst)
        begin
            awaddr_reg    <= {ADDR_W{1'b0}};
            wdata_reg     <= 32'h00000000;
            wstrb0_reg    <= 1'b0;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BTG_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_have_reg && !s_axi_awready)
            begin
                s_axi_awready <= 1'b1;
                awaddr_reg    <= s_axi_awaddr;
                aw_have_reg   <= 1'b1;
            end
            if (s_axi_wvalid && !w_have_reg && !s_axi_wready)
            begin
                s_axi_wready <= 1'b1;
                wdata_reg    <= s_axi_wdata;
                wstrb0_reg   <= s_axi_wstrb[0];
                w_have_reg   <= 1'b1;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                if (hit_env || hit_shot || hit_freq || hit_duty)
                    s_axi_bresp <= `BTG_RESP_OKAY;
                else
                    s_axi_bresp <= `BTG_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
            end
        end
    end

    // Read mux
    always @*
    begin
        rd_data = 32'h00000000;
        rd_ok   = 1'b1;
        // write-only and unused bits read zero
        if (rd_idx == `BTG_IDX_ENV_CTRL)
            rd_data[3:0] = {step_sel_reg, 1'b0, env_en_reg, enable_reg};
        else if (rd_idx == `BTG_IDX_ONESHOT)
            rd_data[3:0] = {2'h0, busy_reg, len_sel_reg};
        else if (rd_idx == `BTG_IDX_FREQ)
            rd_data[3:0] = {1'b0, freq_reg};
        else if (rd_idx == `BTG_IDX_DUTY)
            rd_data[3:0] = {1'b0, duty_reg};
        else
            rd_ok = 1'b0;
    end

    // AXI read channel
    always @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `BTG_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
            begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_data;
                s_axi_rresp   <= rd_ok ? `BTG_RESP_OKAY
                                       : `BTG_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // btg_top
`default_nettype wire

// ==== verification/btg_top_assertions.sv ====
// Purpose: Port assertions for the tone generator
// Assumes: Write address and data offered together
// Notes:   Bound to btg_top after the module
`timescale 1ns/100ps
`default_nettype none
module btg_top_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        low_speed_osc_clock,
    input wire logic        tone_out_pin,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    logic       osc_reg;
    logic [5:0] hi_reg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Oscillator edges while pin high
    always_ff @(posedge clk)
    begin
        osc_reg <= low_speed_osc_clock;
        if (rst || !tone_out_pin)
            hi_reg <= 6'h00;
        else if (osc_reg != low_speed_osc_clock && hi_reg != 6'h3F)
            hi_reg <= hi_reg + 6'h01;
    end
    AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("bvalid dropped early");
    AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready
        |=> s_axi_bvalid) else $error("write not answered in time");
    AST_NO_AW_IN_B: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during response");
    AST_AR_ANSWER: assert property ($rose(s_axi_arvalid) && !s_axi_rvalid
        |=> s_axi_arready && s_axi_rvalid) else $error("read late");
    AST_RDATA_UPPER: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0000000)
        else $error("upper read bits set");
    AST_RESET_IDLE: assert property (
        $fell(rst) |-> !tone_out_pin && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs busy after reset");
    AST_HIGH_LIMIT: assert property (
        tone_out_pin |-> hi_reg <= 6'h19) else $error("tone high too long");
endmodule // btg_top_chk
bind btg_top btg_top_chk i_btg_top_chk (
    .clk,
    .rst,
    .low_speed_osc_clock,
    .tone_out_pin,
    .s_axi_awvalid,
    .s_axi_awready,
    .s_axi_bvalid,
    .s_axi_bready,
    .s_axi_arvalid,
    .s_axi_arready,
    .s_axi_rvalid,
    .s_axi_rdata
);
`default_nettype wire

// ==== verification/btg_buzzer_model.sv ====
// Purpose: Buzzer load that times the tone pin
// Assumes: Pin sampled on the system clock
// Notes:   Run lengths in clock cycles
`timescale 1ns/100ps
`default_nettype none
module btg_buzzer_model (
    input  wire logic clk,
    input  wire logic pin,
    output var int    hi_len,
    output var int    lo_len,
    output var int    rises
);
    int   run_len = 0;
    logic last_q  = 1'b0;
    // Length of each finished run
    always @(posedge clk)
    begin
        last_q <= pin;
        if (pin === last_q)
            run_len <= run_len + 1;
        else
        begin
            run_len <= 1;
            if (pin)
            begin
                lo_len <= run_len;
                rises  <= rises + 1;
            end
            else
                hi_len <= run_len;
        end
    end
endmodule // btg_buzzer_model
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: Self-checking bench for the tone generator
// Assumes: Oscillator input toggles every 4 clocks
// Notes:   Tone times expected from a duty model
`timescale 1ns/100ps
`default_nettype none
`include "btg_defines.vh"
module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        osc = 1'b0;
    logic        pin, awready, wready, bvalid, arready, rvalid;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [17:0] awaddr = 18'h00000;
    logic [17:0] araddr = 18'h00000;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, rd_q;
    logic [1:0]  bresp, rresp, rsp_q;
    logic [31:0] wv [4] = '{32'hFFFFFFFE, 32'hFFFFFFF5, 32'hFFFFFFFF,
                            32'hFFFFFFFF};
    logic [31:0] ev [4] = '{32'hA, 32'h1, 32'h7, 32'h7};
    int          fails = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          hi_len, lo_len, rises, lvl, r0, el;
    initial
    begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc % 4 == 3)
            osc <= ~osc;
    end
    btg_top i_btg_top (
        .clk(clk),
        .rst(rst),
        .low_speed_osc_clock(osc),
        .tone_out_pin(pin),
        .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid),
        .s_axi_awready(awready),
        .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid),
        .s_axi_wready(wready),
        .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid),
        .s_axi_bready(bready),
        .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid),
        .s_axi_arready(arready),
        .s_axi_rdata(rdata),
        .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid),
        .s_axi_rready(rready)
    );
    btg_buzzer_model i_btg_buzzer_model (
        .clk(clk),
        .pin(pin),
        .hi_len(hi_len),
        .lo_len(lo_len),
        .rises(rises)
    );
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] i,
                       input logic [31:0] d);
        logic done;
        done = 1'b0;
        awaddr <= {i, 2'b00};
        araddr <= {i, 2'b00};
        wdata <= d;
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        while (!done)
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (arready)
                arvalid <= 1'b0;
            if (bvalid || rvalid)
            begin
                rd_q = rdata;
                rsp_q = w ? bresp : rresp;
                done = 1'b1;
            end
        end
        bready <= 1'b0;
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_rises(input int n);
        r0 = rises;
        for (int i = 0; i < 3000 && rises < r0 + n; i++)
            @(posedge clk);
    endtask
    task automatic poll;
        int t0;
        t0 = cyc;
        do
            bus(0, `BTG_IDX_ONESHOT, 0);
        while (rd_q[1] === 1'b1 && cyc - t0 < 40000);
        el = cyc - t0;
    endtask
    function automatic int exp_hi(input int c, input int l);
        return ((c & 2) ? 12 : 8) - l << ((c >> 2) & 1);
    endfunction
    function automatic int exp_per(input int c);
        return (16 + 4 * (c & 3)) << ((c >> 2) & 1);
    endfunction
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog well past the expected 67000 cycles
    initial
    begin
        repeat (100000) @(posedge clk);
        fails++;
        wrap_up;
    end
    initial
    begin
        void'($urandom(83));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            bus(0, `BTG_IDX_ENV_CTRL + i[15:0], 0);
            chk(rd_q, 32'h0);
            bus(1, `BTG_IDX_ENV_CTRL + i[15:0], wv[i]);
            bus(0, `BTG_IDX_ENV_CTRL + i[15:0], 0);
            chk(rd_q, ev[i]);
        end
        bus(0, 16'hFF70, 0);
        chk(rsp_q, `BTG_RESP_SLVERR);
        chk(rd_q, 32'h0);
        bus(1, 16'hFF70, 1);
        chk(rsp_q, `BTG_RESP_SLVERR);
        $display("test registers done");
        bus(1, `BTG_IDX_ONESHOT, 0);
        bus(1, `BTG_IDX_ENV_CTRL, 1);
        for (int c = 0; c < 8; c++)
        begin
            lvl = $urandom % 8;
            bus(1, `BTG_IDX_FREQ, c);
            bus(1, `BTG_IDX_DUTY, lvl);
            wait_rises(3);
            chk(hi_len, 4 * exp_hi(c, lvl));
            chk(lo_len, 4 * (exp_per(c) - exp_hi(c, lvl)));
        end
        bus(1, `BTG_IDX_ENV_CTRL, 0);
        wait_rises(0);
        repeat (400) @(posedge clk);
        chk(rises - r0, 0);
        chk(pin, 0);
        $display("test tone done");
        bus(1, `BTG_IDX_FREQ, 0);
        bus(1, `BTG_IDX_DUTY, 7);
        bus(1, `BTG_IDX_ENV_CTRL, 3);
        wait_rises(3);
        chk(hi_len, 32);
        repeat (17500) @(posedge clk);
        wait_rises(2);
        chk(hi_len, 28);
        bus(1, `BTG_IDX_ENV_CTRL, 15);
        wait_rises(3);
        chk(hi_len, 32);
        repeat (17500) @(posedge clk);
        wait_rises(2);
        chk(hi_len, 32);
        $display("test envelope done");
        bus(1, `BTG_IDX_ENV_CTRL, 2);
        bus(1, `BTG_IDX_DUTY, 3);
        bus(1, `BTG_IDX_ONESHOT, 2);
        bus(0, `BTG_IDX_ONESHOT, 0);
        chk(rd_q, 2);
        repeat (5000) @(posedge clk);
        chk(hi_len, 20);
        bus(1, `BTG_IDX_ONESHOT, 2);
        poll;
        chk(el >= 8192 && el <= 9300, 1);
        wait_rises(0);
        repeat (300) @(posedge clk);
        chk(rises - r0, 0);
        bus(1, `BTG_IDX_ONESHOT, 3);
        repeat (12500) @(posedge clk);
        bus(0, `BTG_IDX_ONESHOT, 0);
        chk(rd_q, 3);
        bus(1, `BTG_IDX_ONESHOT, 5);
        poll;
        chk({el <= 1100, rd_q}, {1'b1, 32'h1});
        bus(1, `BTG_IDX_ENV_CTRL, 1);
        bus(1, `BTG_IDX_ONESHOT, 2);
        bus(0, `BTG_IDX_ONESHOT, 0);
        chk(rd_q, 0);
        bus(1, `BTG_IDX_ENV_CTRL, 0);
        $display("test one-shot done");
        wrap_up;
    end
endmodule // tb
`default_nettype wire
